// File: sos_pkg.sv
// constants for the standby controller and crystal stabilization status
// assumes one system clock; crystal cycles arrive as synchronous ticks
package sos_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_STAB_STATUS = 16'hffa3;
  localparam logic [15:0] ADDR_STAB_SELECT = 16'hffa4;
  localparam logic [7:0]  STATUS_RST       = 8'h00;
  localparam logic [2:0]  SELECT_RST       = 3'h5;

  // ----------------------------------------------------------------------
  // status field positions (thermometer, shortest wait in bit 4)
  // ----------------------------------------------------------------------
  localparam int POS_2E11 = 4;
  localparam int POS_2E13 = 3;
  localparam int POS_2E14 = 2;
  localparam int POS_2E15 = 1;
  localparam int POS_2E16 = 0;

  // ----------------------------------------------------------------------
  // select codes and crystal cycle thresholds
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SEL_2E11 = 3'h1;
  localparam logic [2:0]  SEL_2E13 = 3'h2;
  localparam logic [2:0]  SEL_2E14 = 3'h3;
  localparam logic [2:0]  SEL_2E15 = 3'h4;
  localparam logic [2:0]  SEL_2E16 = 3'h5;
  localparam logic [16:0] CYC_2E11 = 17'h00800;
  localparam logic [16:0] CYC_2E13 = 17'h02000;
  localparam logic [16:0] CYC_2E14 = 17'h04000;
  localparam logic [16:0] CYC_2E15 = 17'h08000;
  localparam logic [16:0] CYC_2E16 = 17'h10000;

  // ----------------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SOS_RUN   = 4'b0001,
    SOS_LIGHT = 4'b0010,
    SOS_DEEP  = 4'b0100,
    SOS_WAIT  = 4'b1000
  } sos_state_e;

endpackage

// File: sos_standby_ctrl.sv
// standby controller: light-sleep, deep-sleep, crystal stabilization status
// assumes cpu instruction strobes and crystal ticks are synchronous pulses
`timescale 1ns/1ps

// Summary of operation
// - light-sleep instruction enters light-sleep and gates the cpu clock
// - all running oscillators keep running during light-sleep
// - deep-sleep instruction stops high-speed and internal high-speed osc
// - an interrupt request ends deep-sleep and light-sleep
// - crystal cpu clock waits for stabilization after deep-sleep release
// - registers, flags and memory are held through both standby modes
// - port output latches and buffers are held through both standby modes
// - subsystem oscillator never stops in any standby mode
// - status register is read only, bit or byte readable
// - status clears on reset, deep-sleep instruction and main osc stop
// - status bits 7..5 read zero; bits 4..0 flag 2^11..2^16 cycles
// - flags fill as thermometer from shortest and stay set until cleared
// - counter stops at selected wait, so only flags up to it can set
// - wait counts from start of oscillation, not before
// - status shows crystal progress while cpu runs on another clock
// - select field is three bits, codes 1..5, resets to five
// - crystal cpu clock held off until selected time after deep-sleep
module sos_standby_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        haltInstr,
  input  wire logic        stopInstr,
  input  wire logic        intReq,
  input  wire logic        cpuClkIsCrystal,
  input  wire logic        crystalTick,
  input  wire logic        crystalRunning,
  input  wire logic        mainOscStopSet,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRdEn,
  input  wire logic        memWrEn,
  input  wire logic [7:0]  memWrData,
  output logic             cpuClkEn_ff,
  output logic             hsOscStop_ff,
  output logic             subOscRun_ff,
  output logic             holdState_ff,
  output logic [7:0]       memRdData_ff
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // prohibited codes fall back to the longest wait: safe, never too short
  function automatic logic [16:0] selLimit(input logic [2:0] sel);
    unique case (sel)
      sos_pkg::SEL_2E11: selLimit = sos_pkg::CYC_2E11;
      sos_pkg::SEL_2E13: selLimit = sos_pkg::CYC_2E13;
      sos_pkg::SEL_2E14: selLimit = sos_pkg::CYC_2E14;
      sos_pkg::SEL_2E15: selLimit = sos_pkg::CYC_2E15;
      default:           selLimit = sos_pkg::CYC_2E16;
    endcase
  endfunction

  function automatic logic [4:0] flagsFor(input logic [16:0] cnt);
    flagsFor = '0;
    flagsFor[sos_pkg::POS_2E11] = (cnt >= sos_pkg::CYC_2E11);
    flagsFor[sos_pkg::POS_2E13] = (cnt >= sos_pkg::CYC_2E13);
    flagsFor[sos_pkg::POS_2E14] = (cnt >= sos_pkg::CYC_2E14);
    flagsFor[sos_pkg::POS_2E15] = (cnt >= sos_pkg::CYC_2E15);
    flagsFor[sos_pkg::POS_2E16] = (cnt >= sos_pkg::CYC_2E16);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sos_pkg::sos_state_e state_ff;
  sos_pkg::sos_state_e nxt_state;
  logic [16:0]         stabCnt_ff;
  logic [16:0]         nxt_stabCnt;
  logic [4:0]          stabFlags_ff;
  logic [4:0]          nxt_stabFlags;
  logic [2:0]          stabSelect_ff;
  logic [2:0]          nxt_stabSelect;
  logic                nxt_cpuClkEn;
  logic                nxt_hsOscStop;
  logic                nxt_holdState;
  logic [7:0]          nxt_memRdData;
  logic                stabClear;
  logic                waitDone;

  assign stabClear = (stopInstr && state_ff == sos_pkg::SOS_RUN) ||
                     mainOscStopSet;
  assign waitDone  = (stabCnt_ff >= selLimit(stabSelect_ff));

  // ----------------------------------------------------------------------
  // standby sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sos_pkg::SOS_RUN: begin
        if (stopInstr) begin
          nxt_state = sos_pkg::SOS_DEEP;
        end else if (haltInstr) begin
          nxt_state = sos_pkg::SOS_LIGHT;
        end
      end
      sos_pkg::SOS_LIGHT: begin
        if (intReq) begin
          nxt_state = sos_pkg::SOS_RUN;
        end
      end
      sos_pkg::SOS_DEEP: begin
        if (intReq) begin
          // only a crystal cpu clock has to wait out stabilization
          nxt_state = cpuClkIsCrystal ? sos_pkg::SOS_WAIT
                                      : sos_pkg::SOS_RUN;
        end
      end
      sos_pkg::SOS_WAIT: begin
        if (!cpuClkIsCrystal || waitDone) begin
          nxt_state = sos_pkg::SOS_RUN;
        end
      end
      default: nxt_state = sos_pkg::SOS_RUN;
    endcase
    // cpu clock only in run; oscillators stop only in deep-sleep
    nxt_cpuClkEn  = (nxt_state == sos_pkg::SOS_RUN);
    nxt_hsOscStop = (nxt_state == sos_pkg::SOS_DEEP);
    // freeze of cpu registers, memory and port latches while not running
    nxt_holdState = (nxt_state != sos_pkg::SOS_RUN);
  end

  // ----------------------------------------------------------------------
  // stabilization counter, flags and select register
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_stabCnt    = stabCnt_ff;
    nxt_stabSelect = stabSelect_ff;
    if (stabClear || !crystalRunning) begin
      nxt_stabCnt = '0;
    end else if (crystalTick && !waitDone) begin
      nxt_stabCnt = stabCnt_ff + 17'h00001;
    end
    nxt_stabFlags = stabFlags_ff | flagsFor(stabCnt_ff);
    // clear wins: the counter restarts with it, so a set from the stale
    // count would report stabilization that no longer holds
    if (stabClear) begin
      nxt_stabFlags = 5'h00;
    end
    if (memWrEn && memAddr == sos_pkg::ADDR_STAB_SELECT) begin
      nxt_stabSelect = memWrData[2:0];
    end
    // status has no write path at all
    nxt_memRdData = memRdData_ff;
    if (memRdEn) begin
      if (memAddr == sos_pkg::ADDR_STAB_STATUS) begin
        nxt_memRdData = {3'h0, stabFlags_ff};
      end else if (memAddr == sos_pkg::ADDR_STAB_SELECT) begin
        nxt_memRdData = {5'h00, stabSelect_ff};
      end else begin
        nxt_memRdData = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff      <= sos_pkg::SOS_RUN;
      stabCnt_ff    <= '0;
      stabFlags_ff  <= sos_pkg::STATUS_RST[4:0];
      stabSelect_ff <= sos_pkg::SELECT_RST;
      cpuClkEn_ff   <= 1'b1;
      hsOscStop_ff  <= 1'b0;
      subOscRun_ff  <= 1'b1;
      holdState_ff  <= 1'b0;
      memRdData_ff  <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      stabCnt_ff    <= nxt_stabCnt;
      stabFlags_ff  <= nxt_stabFlags;
      stabSelect_ff <= nxt_stabSelect;
      cpuClkEn_ff   <= nxt_cpuClkEn;
      hsOscStop_ff  <= nxt_hsOscStop;
      subOscRun_ff  <= 1'b1;
      holdState_ff  <= nxt_holdState;
      memRdData_ff  <= nxt_memRdData;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_halt_gates_clock: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff == sos_pkg::SOS_RUN && haltInstr && !stopInstr
    |=> !cpuClkEn_ff && !hsOscStop_ff)
    else $error("light-sleep did not gate cpu clock only");

  a_deep_stops_osc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff == sos_pkg::SOS_RUN && stopInstr
    |=> hsOscStop_ff && stabFlags_ff == 5'h00)
    else $error("deep-sleep did not stop oscillators or clear status");

  a_sub_osc_runs: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 subOscRun_ff)
    else $error("subsystem oscillator stopped");

  a_irq_wakes: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff != sos_pkg::SOS_RUN && state_ff != sos_pkg::SOS_WAIT && intReq
    ##1 1 |-> !hsOscStop_ff)
    else $error("interrupt did not end standby");

  a_wait_holds_cpu: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff == sos_pkg::SOS_WAIT && cpuClkIsCrystal && !waitDone
    |=> !cpuClkEn_ff)
    else $error("cpu released before stabilization");

  a_status_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(memRdEn) && memAddr == sos_pkg::ADDR_STAB_STATUS
    |=> memRdData_ff[7:5] == 3'h0)
    else $error("status upper bits not zero");

  a_flags_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !stabClear && stabFlags_ff[sos_pkg::POS_2E11]
    |=> stabFlags_ff[sos_pkg::POS_2E11])
    else $error("stabilization flag fell without a clear");

  a_flags_limited: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stabSelect_ff == sos_pkg::SEL_2E11 && !stabClear
    && stabFlags_ff[sos_pkg::POS_2E13] == 1'b0
    |=> stabFlags_ff[sos_pkg::POS_2E13] == 1'b0)
    else $error("flag beyond selected wait became set");

  a_hold_standby: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff != sos_pkg::SOS_RUN |-> holdState_ff && !cpuClkEn_ff)
    else $error("state not held in standby");

endmodule // sos_standby_ctrl

// File: sos_xtal_model.sv
// crystal oscillator model on the far side of the standby block
// assumes one system clock; one crystal tick per system cycle once running
`timescale 1ns/1ps
module sos_xtal_model #(
  parameter int START_DLY = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic oscEnable,
  input  wire logic oscHalt,
  output logic      crystalTick,
  output logic      crystalRunning
);
  // ----------------------------------------------------------------------
  // start-up gap, then free ticks
  // ----------------------------------------------------------------------
  logic [7:0] startCnt_ff;
  // the gap before oscillation must not count as stabilization time
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !oscEnable || oscHalt) begin
      startCnt_ff <= 8'h00;
    end else if (startCnt_ff < 8'(START_DLY)) begin
      startCnt_ff <= startCnt_ff + 8'h01;
    end
  end
  assign crystalRunning = (startCnt_ff == 8'(START_DLY));
  assign crystalTick    = crystalRunning;
endmodule // sos_xtal_model

// File: standby_osc_stabilization_bench.sv
// self-checking bench for the standby controller
// assumes the crystal model drives ticks; cpu side is driven by the tasks
`timescale 1ns/1ps
module standby_osc_stabilization_bench;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic        sysClk = 1'b0, rst_b = 1'b0, haltInstr = 1'b0;
  logic        stopInstr = 1'b0, intReq = 1'b0, cpuClkIsCrystal = 1'b0;
  logic        oscEn = 1'b0, mainOscStopSet = 1'b0, memRdEn = 1'b0;
  logic        memWrEn = 1'b0, crystalTick, crystalRunning;
  logic        cpuClkEn_ff, hsOscStop_ff, subOscRun_ff, holdState_ff;
  logic [15:0] memAddr = 16'h0000;
  logic [7:0]  memWrData = 8'h00, memRdData_ff;
  int          n_fail = 0, compares = 0, cyc = 0;
  sos_standby_ctrl u_sos_standby_ctrl (.sys_clk(sysClk), .rst_b(rst_b),
    .haltInstr(haltInstr), .stopInstr(stopInstr), .intReq(intReq),
    .cpuClkIsCrystal(cpuClkIsCrystal), .crystalTick(crystalTick),
    .crystalRunning(crystalRunning), .mainOscStopSet(mainOscStopSet),
    .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn),
    .memWrData(memWrData), .cpuClkEn_ff(cpuClkEn_ff),
    .hsOscStop_ff(hsOscStop_ff), .subOscRun_ff(subOscRun_ff),
    .holdState_ff(holdState_ff), .memRdData_ff(memRdData_ff));
  sos_xtal_model u_sos_xtal_model (.sys_clk(sysClk), .rst_b(rst_b),
    .oscEnable(oscEn), .oscHalt(hsOscStop_ff), .crystalTick(crystalTick),
    .crystalRunning(crystalRunning));
  initial forever #10 sysClk = ~sysClk;
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] st();
    return {4'h0, cpuClkEn_ff, hsOscStop_ff, subOscRun_ff, holdState_ff};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sysClk) begin memRdEn <= 1'b1; memAddr <= a; end
    @(posedge sysClk) memRdEn <= 1'b0;
    #1 chk(memRdData_ff, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sysClk) begin memWrEn <= 1'b1; memAddr <= a; end
    memWrData <= d;
    @(posedge sysClk) memWrEn <= 1'b0;
  endtask
  task automatic instr(input logic deep);
    @(posedge sysClk) if (deep) stopInstr <= 1'b1; else haltInstr <= 1'b1;
    @(posedge sysClk) begin stopInstr <= 1'b0; haltInstr <= 1'b0; end
    #1;
  endtask
  task automatic wake(input int lim);
    int i;
    i = 0;
    @(posedge sysClk) intReq <= 1'b1;
    while (cpuClkEn_ff !== 1'b1 && i < lim) begin @(posedge sysClk); #1 i++; end
    chk(st(), 8'h0a);
    @(posedge sysClk) intReq <= 1'b0;
  endtask
  task conclude;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    #1 chk(st(), 8'h0a);
    rd(16'hffa3, 8'h00);
    rd(16'hffa4, 8'h05);
    wr(16'hffa3, 8'hff);
    rd(16'hffa3, 8'h00);
    rd(16'h1234, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_light;
    instr(1'b0);
    chk(st(), 8'h03);
    repeat (5) @(posedge sysClk);
    #1 chk(st(), 8'h03);
    wake(3);
    $display("test light done");
  endtask
  task automatic t_count;
    wr(16'hffa4, 8'h02);
    rd(16'hffa4, 8'h02);
    @(posedge sysClk) oscEn <= 1'b1;
    repeat (2040) @(posedge sysClk);
    rd(16'hffa3, 8'h00);
    repeat (20) @(posedge sysClk);
    rd(16'hffa3, 8'h10);
    repeat (14400) @(posedge sysClk);
    rd(16'hffa3, 8'h18);
    @(posedge sysClk) begin oscEn <= 1'b0; mainOscStopSet <= 1'b1; end
    @(posedge sysClk) mainOscStopSet <= 1'b0;
    rd(16'hffa3, 8'h00);
    $display("test count done");
  endtask
  task automatic t_deep;
    wr(16'hffa4, 8'h01);
    @(posedge sysClk) begin oscEn <= 1'b1; cpuClkIsCrystal <= 1'b1; end
    repeat (2100) @(posedge sysClk);
    rd(16'hffa3, 8'h10);
    instr(1'b1);
    chk(st(), 8'h07);
    rd(16'hffa3, 8'h00);
    fork wake(2100); begin repeat (2000) @(posedge sysClk); #2; end join_any
    chk(st(), 8'h03);
    wait (intReq === 1'b0);
    @(posedge sysClk) cpuClkIsCrystal <= 1'b0;
    instr(1'b1);
    wake(4);
    $display("test deep done");
  endtask
  always @(posedge sysClk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge sysClk);
    rst_b <= 1'b1;
    t_regs();
    t_light();
    t_count();
    t_deep();
    conclude();
  end
endmodule // standby_osc_stabilization_bench
